// ---- rtl/sewp_consts.svh ----
// constants shared by both ends of the two-wire eeprom link
`ifndef SEWP_CONSTS_SVH
`define SEWP_CONSTS_SVH

// ---------------------------------------------------------------
// control byte layout
// ---------------------------------------------------------------
// device code value is arbitrary
`define SEWP_DEV_CODE 4'h5
`define SEWP_CODE_HI 7
`define SEWP_CODE_LO 4
`define SEWP_RW_BIT 0
`define SEWP_ADDR_W 4
`define SEWP_MEM_DEPTH 16
`define SEWP_ACK_SLOT 4'h8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SEWP_CLK_NS 25
`define SEWP_TWC_NS 1000000
`define SEWP_TWC_CYC ((`SEWP_TWC_NS + `SEWP_CLK_NS - 1) / `SEWP_CLK_NS)
`define SEWP_SCL_NS 2500
`define SEWP_QTR_CYC (`SEWP_SCL_NS / 4 / `SEWP_CLK_NS)

`endif

// ---- rtl/sewp_pkg.sv ----
// types shared by both ends of the two-wire eeprom link
`default_nettype none
package sewp_pkg;

    typedef enum logic [4:0] {
        DS_IDLE  = 5'h01,
        DS_CTRL  = 5'h02,
        DS_ADDR  = 5'h04,
        DS_WDATA = 5'h08,
        DS_RDATA = 5'h10
    } sewp_dstate_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'h1,
        HS_RUN  = 2'h2
    } sewp_hstate_t;

    typedef enum logic [6:0] {
        K_START = 7'h01,
        K_CTRLW = 7'h02,
        K_CTRLR = 7'h04,
        K_ADDR  = 7'h08,
        K_DATA  = 7'h10,
        K_RBYTE = 7'h20,
        K_STOP  = 7'h40
    } sewp_kind_t;

    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_POLL  = 2'h1,
        OP_RCUR  = 2'h2,
        OP_RRND  = 2'h3
    } sewp_op_t;

endpackage
`default_nettype wire

// ---- rtl/sewp_if.sv ----
// open-drain two-wire link joining host and eeprom ends
`default_nettype none
interface sewp_if;
    logic h_scl_o;
    logic h_scl_oe;
    logic h_sda_o;
    logic h_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up: a line is low while any enabled driver pulls it low
    assign scl = ~(h_scl_oe & ~h_scl_o);
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
    modport host (input scl, input sda, output h_scl_o, output h_scl_oe,
                  output h_sda_o, output h_sda_oe);
endinterface
`default_nettype wire

// ---- rtl/sewp_dev.sv ----
// eeprom end of the two-wire link: 16-byte store, byte write, polling, reads
`include "sewp_consts.svh"
`default_nettype none
module sewp_dev #(
    parameter int unsigned TWC_CYC = `SEWP_TWC_CYC,
    parameter int unsigned DEPTH = `SEWP_MEM_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // two-wire link
    sewp_if.dev bus,
    // write cycle status
    output logic wr_busy,
    output logic wr_pulse,
    output logic [3:0] wr_addr,
    output logic [7:0] wr_data
);

    localparam int unsigned TW = $clog2(TWC_CYC + 1);

    if (DEPTH != (1 << `SEWP_ADDR_W) || TWC_CYC < 1) begin : g_bad_param
        $error("sewp_dev: depth must match address width, cycle at least 1");
    end

    // ---------------------------------------------------------------
    // line synchronisers
    // ---------------------------------------------------------------
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic scl_f_q;
    logic sda_f_q;
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[1:0], bus.scl};
            sda_s_q <= {sda_s_q[1:0], bus.sda};
            // a level counts only once the second and third stages agree
            if (scl_s_q[1] == scl_s_q[2]) begin
                scl_f_q <= scl_s_q[2];
            end
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_f_q <= sda_s_q[2];
            end
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign scl_rise = scl_f_q & ~scl_p_q;
    assign scl_fall = ~scl_f_q & scl_p_q;
    assign start_ev = scl_f_q & scl_p_q & ~sda_f_q & sda_p_q;
    assign stop_ev = scl_f_q & scl_p_q & sda_f_q & ~sda_p_q;

    // ---------------------------------------------------------------
    // shared state and events
    // ---------------------------------------------------------------
    sewp_pkg::sewp_dstate_t st_q;
    logic [3:0] cnt_q;
    logic in_ack_q;
    logic [7:0] shift_q;
    logic [7:0] buf_q;
    logic have_q;
    logic [3:0] ptr_q;
    logic sda_oe_q;
    logic [TW-1:0] twc_q;
    logic [7:0] mem [DEPTH];

    logic active;
    logic byte_end;
    logic code_ok;
    logic ack_ok;
    logic commit_go;

    assign active = (st_q != sewp_pkg::DS_IDLE);
    assign byte_end = active & scl_fall & ~in_ack_q & (cnt_q == `SEWP_ACK_SLOT);
    assign code_ok = (shift_q[`SEWP_CODE_HI:`SEWP_CODE_LO] == `SEWP_DEV_CODE);

    always_comb begin
        unique case (st_q)
            sewp_pkg::DS_CTRL: ack_ok = byte_end & code_ok & ~wr_busy;
            sewp_pkg::DS_ADDR: ack_ok = byte_end;
            sewp_pkg::DS_WDATA: ack_ok = byte_end;
            default: ack_ok = 1'b0;
        endcase
    end

    // only a stop right after a whole acknowledged data byte commits; the
    // stop's own clock pulse has already been counted as one bit by then
    assign commit_go = stop_ev & (st_q == sewp_pkg::DS_WDATA) & have_q
        & ~in_ack_q & (cnt_q[3:1] == 3'h0);

    // ---------------------------------------------------------------
    // command sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= sewp_pkg::DS_IDLE;
            cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
            shift_q <= 8'h00;
            buf_q <= 8'h00;
            have_q <= 1'b0;
        end else if (start_ev) begin
            // a repeated start keeps the pointer set by the address byte
            st_q <= sewp_pkg::DS_CTRL;
            cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
            have_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= sewp_pkg::DS_IDLE;
            cnt_q <= 4'h0;
            in_ack_q <= 1'b0;
            have_q <= 1'b0;
        end else if (active && scl_rise) begin
            if (cnt_q != `SEWP_ACK_SLOT) begin
                shift_q <= {shift_q[6:0], sda_f_q};
                cnt_q <= cnt_q + 4'h1;
            end else if (st_q == sewp_pkg::DS_RDATA && !in_ack_q) begin
                if (sda_f_q) begin
                    st_q <= sewp_pkg::DS_IDLE;
                end else begin
                    cnt_q <= 4'h0;
                end
            end
        end else if (active && scl_fall) begin
            if (in_ack_q) begin
                in_ack_q <= 1'b0;
                cnt_q <= 4'h0;
            end else if (byte_end && st_q != sewp_pkg::DS_RDATA) begin
                if (!ack_ok) begin
                    st_q <= sewp_pkg::DS_IDLE;
                end else begin
                    in_ack_q <= 1'b1;
                    unique case (st_q)
                        sewp_pkg::DS_CTRL: begin
                            st_q <= shift_q[`SEWP_RW_BIT] ? sewp_pkg::DS_RDATA
                                : sewp_pkg::DS_ADDR;
                        end
                        sewp_pkg::DS_ADDR: st_q <= sewp_pkg::DS_WDATA;
                        default: begin
                            // each further full byte replaces the one held
                            buf_q <= shift_q;
                            have_q <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // address pointer
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q <= 4'h0;
        end else if (byte_end && st_q == sewp_pkg::DS_ADDR) begin
            ptr_q <= shift_q[3:0];
        end else if (byte_end && st_q == sewp_pkg::DS_RDATA) begin
            ptr_q <= ptr_q + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // data line driver
    // ---------------------------------------------------------------
    // drive is taken only after a clock fall and dropped on start or stop, so it never mimics start or stop
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_oe_q <= 1'b0;
        end else if (start_ev || stop_ev) begin
            sda_oe_q <= 1'b0;
        end else if (active && scl_fall) begin
            if (in_ack_q) begin
                sda_oe_q <= (st_q == sewp_pkg::DS_RDATA) & ~mem[ptr_q][7];
            end else if (cnt_q == `SEWP_ACK_SLOT) begin
                sda_oe_q <= ack_ok;
            end else if (st_q == sewp_pkg::DS_RDATA) begin
                sda_oe_q <= ~mem[ptr_q][~cnt_q[2:0]];
            end
        end
    end

    assign bus.d_sda_oe = sda_oe_q;
    assign bus.d_sda_o = 1'b0;

    // ---------------------------------------------------------------
    // internal write cycle and store
    // ---------------------------------------------------------------
    // the pointer is not advanced by a write, so a following current read
    // returns the byte just written
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_busy <= 1'b0;
            wr_pulse <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            twc_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
        end else begin
            wr_pulse <= 1'b0;
            if (commit_go) begin
                wr_busy <= 1'b1;
                wr_addr <= ptr_q;
                wr_data <= buf_q;
                twc_q <= '0;
            end else if (wr_busy) begin
                if (twc_q == TW'(TWC_CYC - 1)) begin
                    wr_busy <= 1'b0;
                    wr_pulse <= 1'b1;
                    mem[wr_addr] <= wr_data;
                end else begin
                    twc_q <= twc_q + TW'(1);
                end
            end
        end
    end

endmodule // sewp_dev
`default_nettype wire

// ---- rtl/sewp_host.sv ----
// master end of the two-wire link: makes the clock, runs write, poll, reads
`include "sewp_consts.svh"
`default_nettype none
module sewp_host #(
    parameter int unsigned QTR = `SEWP_QTR_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // two-wire link
    sewp_if.host bus,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sewp_pkg::sewp_op_t cmd_op,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    // response
    output logic rsp_valid,
    output logic rsp_ack,
    output logic [7:0] rsp_data
);

    localparam int unsigned QW = $clog2(QTR + 1);

    // below eight cycles the eeprom's line filter cannot follow the clock
    if (QTR < 8) begin : g_bad_param
        $error("sewp_host: quarter period too short");
    end

    // ---------------------------------------------------------------
    // data line synchroniser
    // ---------------------------------------------------------------
    logic [2:0] sda_s_q;
    logic sda_f_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_s_q <= 3'h7;
            sda_f_q <= 1'b1;
        end else begin
            sda_s_q <= {sda_s_q[1:0], bus.sda};
            if (sda_s_q[1] == sda_s_q[2]) begin
                sda_f_q <= sda_s_q[2];
            end
        end
    end

    // ---------------------------------------------------------------
    // clock divider
    // ---------------------------------------------------------------
    sewp_pkg::sewp_hstate_t st_q;
    logic [QW-1:0] div_q;
    logic [1:0] qtr_q;
    logic tick;

    assign tick = (st_q == sewp_pkg::HS_RUN) && (div_q == QW'(QTR - 1));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= '0;
            qtr_q <= 2'h0;
        end else if (st_q != sewp_pkg::HS_RUN || tick) begin
            div_q <= '0;
            qtr_q <= (st_q == sewp_pkg::HS_RUN) ? qtr_q + 2'h1 : 2'h0;
        end else begin
            div_q <= div_q + QW'(1);
        end
    end

    // ---------------------------------------------------------------
    // element sequence per command
    // ---------------------------------------------------------------
    sewp_pkg::sewp_op_t op_q;
    logic [2:0] step_q;
    logic [3:0] bit_q;
    logic abort_q;
    logic [3:0] addr_q;
    logic [7:0] data_q;
    sewp_pkg::sewp_kind_t kind;
    logic [7:0] tx_byte;
    logic last_q;

    always_comb begin
        kind = sewp_pkg::K_STOP;
        if (!abort_q) begin
            unique case (op_q)
                sewp_pkg::OP_WRITE: begin
                    case (step_q)
                        3'h0: kind = sewp_pkg::K_START;
                        3'h1: kind = sewp_pkg::K_CTRLW;
                        3'h2: kind = sewp_pkg::K_ADDR;
                        3'h3: kind = sewp_pkg::K_DATA;
                        default: kind = sewp_pkg::K_STOP;
                    endcase
                end
                sewp_pkg::OP_POLL: begin
                    case (step_q)
                        3'h0: kind = sewp_pkg::K_START;
                        3'h1: kind = sewp_pkg::K_CTRLW;
                        default: kind = sewp_pkg::K_STOP;
                    endcase
                end
                sewp_pkg::OP_RCUR: begin
                    case (step_q)
                        3'h0: kind = sewp_pkg::K_START;
                        3'h1: kind = sewp_pkg::K_CTRLR;
                        3'h2: kind = sewp_pkg::K_RBYTE;
                        default: kind = sewp_pkg::K_STOP;
                    endcase
                end
                sewp_pkg::OP_RRND: begin
                    case (step_q)
                        3'h0: kind = sewp_pkg::K_START;
                        3'h1: kind = sewp_pkg::K_CTRLW;
                        3'h2: kind = sewp_pkg::K_ADDR;
                        3'h3: kind = sewp_pkg::K_START;
                        3'h4: kind = sewp_pkg::K_CTRLR;
                        3'h5: kind = sewp_pkg::K_RBYTE;
                        default: kind = sewp_pkg::K_STOP;
                    endcase
                end
            endcase
        end
    end

    always_comb begin
        unique case (kind)
            sewp_pkg::K_CTRLW: tx_byte = {`SEWP_DEV_CODE, 4'h0};
            sewp_pkg::K_CTRLR: tx_byte = {`SEWP_DEV_CODE, 4'h1};
            sewp_pkg::K_ADDR: tx_byte = {4'h0, addr_q};
            sewp_pkg::K_DATA: tx_byte = data_q;
            default: tx_byte = 8'hFF;
        endcase
    end

    logic is_byte;
    assign is_byte = (kind != sewp_pkg::K_START) && (kind != sewp_pkg::K_STOP);

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= sewp_pkg::HS_IDLE;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_ack <= 1'b0;
            rsp_data <= 8'h00;
            op_q <= sewp_pkg::OP_WRITE;
            addr_q <= 4'h0;
            data_q <= 8'h00;
            step_q <= 3'h0;
            bit_q <= 4'h0;
            abort_q <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (st_q == sewp_pkg::HS_IDLE) begin
                cmd_ready <= 1'b1;
                if (cmd_valid && cmd_ready) begin
                    cmd_ready <= 1'b0;
                    st_q <= sewp_pkg::HS_RUN;
                    op_q <= cmd_op;
                    addr_q <= cmd_addr;
                    data_q <= cmd_data;
                    step_q <= 3'h0;
                    bit_q <= 4'h0;
                    abort_q <= 1'b0;
                    rsp_ack <= 1'b1;
                end
            end else if (tick && qtr_q == 2'h2 && is_byte) begin
                if (bit_q != `SEWP_ACK_SLOT) begin
                    if (kind == sewp_pkg::K_RBYTE) begin
                        rsp_data <= {rsp_data[6:0], sda_f_q};
                    end
                end else if (kind != sewp_pkg::K_RBYTE && sda_f_q) begin
                    rsp_ack <= 1'b0;
                end
            end else if (tick && qtr_q == 2'h3) begin
                if (kind == sewp_pkg::K_STOP) begin
                    st_q <= sewp_pkg::HS_IDLE;
                    rsp_valid <= 1'b1;
                end else if (!is_byte) begin
                    step_q <= step_q + 3'h1;
                end else if (bit_q != `SEWP_ACK_SLOT) begin
                    bit_q <= bit_q + 4'h1;
                end else begin
                    bit_q <= 4'h0;
                    if (kind != sewp_pkg::K_RBYTE && !rsp_ack) begin
                        if (op_q == sewp_pkg::OP_POLL) begin
                            // busy eeprom: restart and poll again
                            step_q <= 3'h0;
                            rsp_ack <= 1'b1;
                        end else begin
                            abort_q <= 1'b1;
                        end
                    end else begin
                        step_q <= step_q + 3'h1;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // line drivers
    // ---------------------------------------------------------------
    logic scl_oe_q;
    logic sda_oe_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (st_q != sewp_pkg::HS_RUN) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (tick) begin
            unique case (qtr_q)
                2'h0: begin
                    if (kind == sewp_pkg::K_STOP) begin
                        sda_oe_q <= 1'b1;
                    end else if (kind == sewp_pkg::K_START) begin
                        sda_oe_q <= 1'b0;
                    end else begin
                        // ack slot and every read bit are left released
                        sda_oe_q <= (bit_q != `SEWP_ACK_SLOT)
                            & ~tx_byte[~bit_q[2:0]] & (kind != sewp_pkg::K_RBYTE);
                    end
                end
                2'h1: scl_oe_q <= 1'b0;
                2'h2: begin
                    if (kind == sewp_pkg::K_START) begin
                        sda_oe_q <= 1'b1;
                    end else if (kind == sewp_pkg::K_STOP) begin
                        sda_oe_q <= 1'b0;
                    end
                end
                2'h3: scl_oe_q <= (kind != sewp_pkg::K_STOP);
            endcase
        end
    end

    assign bus.h_scl_oe = scl_oe_q;
    assign bus.h_sda_oe = sda_oe_q;
    assign bus.h_scl_o = 1'b0;
    assign bus.h_sda_o = 1'b0;

endmodule // sewp_host
`default_nettype wire

// ---- tb/sewp_chk.sv ----
// assertions on the two-wire link between host and eeprom ends
`default_nettype none
module sewp_chk (
    // link signals
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic h_sda_oe,
    input wire logic d_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_start; scl && $past(scl) && !sda && $past(sda); endsequence
    sequence s_stop; scl && $past(scl) && sda && !$past(sda); endsequence
    property p_rst_idle; $rose(reset_n) |-> scl && sda && !d_sda_oe; endproperty
    property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
    property p_start_gap; s_start |-> $past(sda, 12) && $past(scl, 4); endproperty
    property p_stop_gap; s_stop |-> (sda && scl) [*8]; endproperty
    property p_stop_quiet; s_stop |-> !d_sda_oe [*8]; endproperty
    property p_dev_rise; $rose(d_sda_oe) |-> !scl && $past(scl, 10); endproperty
    property p_dev_hold; scl && $past(scl) |-> $stable(d_sda_oe); endproperty
    property p_no_fight; d_sda_oe && scl |-> !h_sda_oe; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    a_start_gap: assert property (p_start_gap) else $error("start without idle");
    a_stop_gap: assert property (p_stop_gap) else $error("no idle after stop");
    a_stop_quiet: assert property (p_stop_quiet) else $error("eeprom drives after stop");
    a_dev_rise: assert property (p_dev_rise) else $error("eeprom drives off clock low");
    a_dev_hold: assert property (p_dev_hold) else $error("eeprom bit moved in high");
    a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
    c_start: cover property (s_start);
    c_stop: cover property (s_stop);
    c_ack: cover property ($rose(d_sda_oe));
endmodule // sewp_chk
`default_nettype wire

// ---- tb/tb_serial_eeprom_write_poll.sv ----
// self-checking bench: host and eeprom ends, plus a bit-banged second link
`include "sewp_consts.svh"
`default_nettype none
module tb_serial_eeprom_write_poll;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0;
    logic reset_n, cmd_valid, cmd_ready, rsp_valid, rsp_ack, pulse1, pulse2, busy1;
    sewp_pkg::sewp_op_t cmd_op;
    logic [3:0] cmd_addr, waddr1, waddr2, a, b;
    logic [7:0] cmd_data, rsp_data, wdata1, wdata2, d;
    logic [7:0] mem [16] = '{default: 8'h00};
    int fails = 0;
    int check_count = 0;
    int pulses1 = 0;
    int pulses2 = 0;
    sewp_if link ();
    sewp_if l2 ();
    sewp_host #(.QTR(8)) sewp_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .bus(link.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_data(rsp_data));
    sewp_dev #(.TWC_CYC(800)) sewp_dev_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus(link.dev), .wr_busy(busy1), .wr_pulse(pulse1), .wr_addr(waddr1), .wr_data(wdata1));
    // second eeprom faces a bench driver that sends both whole writes and write sequences broken on purpose
    sewp_dev #(.TWC_CYC(800)) sewp_dev_inst2 (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus(l2.dev), .wr_busy(), .wr_pulse(pulse2), .wr_addr(waddr2), .wr_data(wdata2));
    sewp_chk sewp_chk_inst (.ref_clk(ref_clk), .reset_n(reset_n), .scl(link.scl),
        .sda(link.sda), .h_sda_oe(link.h_sda_oe), .d_sda_oe(link.d_sda_oe));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (pulse1 === 1'h1) pulses1++;
        if (pulse2 === 1'h1) pulses2++;
    end
    function automatic logic [7:0] ctrl_byte(input logic rw);
        return {`SEWP_DEV_CODE, 3'h0, rw};
    endfunction
    task automatic finish_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(input sewp_pkg::sewp_op_t op, input logic [3:0] ad, input logic [7:0] dt);
        int n;
        n = 0;
        while (cmd_ready !== 1'h1 && n < 9000) begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_addr <= ad;
        cmd_data <= dt;
        @(posedge ref_clk);
        cmd_valid <= 1'h0;
        while (rsp_valid !== 1'h1 && n < 9000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 9000) begin
            fails++;
            finish_test();
        end
    endtask
    // one quarter of a bit with the given clock and data pull-downs
    task automatic drv(input logic c, input logic s);
        l2.h_scl_oe <= c;
        l2.h_sda_oe <= s;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic send_bit(input logic v, output logic s);
        drv(1'h1, ~v);
        drv(1'h0, ~v);
        s = l2.sda;
        drv(1'h0, ~v);
        drv(1'h1, ~v);
    endtask
    task automatic send_byte(input logic [7:0] v, output logic ak);
        logic s;
        for (int i = 7; i >= 0; i--) send_bit(v[i], s);
        send_bit(1'h1, s);
        ak = ~s;
    endtask
    task automatic bb_case(input logic [31:0] bs, input int nb, input int nx, input logic ea,
            input logic ec, input logic [7:0] ead, input logic [7:0] eda);
        logic ak, s, all;
        int p0;
        p0 = pulses2;
        all = 1'h1;
        @(posedge ref_clk);
        drv(1'h0, 1'h0);
        drv(1'h0, 1'h1);
        drv(1'h1, 1'h1);
        for (int k = 0; k < nb; k++) begin
            send_byte(bs[8 * (3 - k) +: 8], ak);
            all = all & ak;
        end
        for (int j = 0; j < nx; j++) send_bit(1'($urandom), s);
        drv(1'h1, 1'h1);
        drv(1'h0, 1'h1);
        drv(1'h0, 1'h0);
        repeat (900) @(posedge ref_clk);
        chk_bit("bb ack", ea, all);
        chk_byte("bb commits", 8'(p0 + ec), 8'(pulses2));
        if (ec) begin
            chk_byte("bb addr", ead, {4'h0, waddr2});
            chk_byte("bb data", eda, wdata2);
        end
    endtask
    initial begin
        reset_n = 1'h0;
        cmd_valid = 1'h0;
        cmd_op = sewp_pkg::OP_WRITE;
        cmd_addr = 4'h0;
        cmd_data = 8'h00;
        l2.h_scl_o = 1'h0;
        l2.h_sda_o = 1'h0;
        l2.h_scl_oe = 1'h0;
        l2.h_sda_oe = 1'h0;
        void'($urandom(57));
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (2) @(negedge ref_clk);
        bb_case({ctrl_byte(0), 16'h03A5, 8'h00}, 3, 0, 1, 1, 8'h03, 8'hA5);
        bb_case({ctrl_byte(0), 16'hF73C, 8'h00}, 3, 0, 1, 1, 8'h07, 8'h3C);
        bb_case({ctrl_byte(0), 8'h05, 16'h0000}, 2, 0, 1, 0, 8'h00, 8'h00);
        bb_case({ctrl_byte(0), 24'h061122}, 4, 0, 1, 1, 8'h06, 8'h22);
        bb_case({ctrl_byte(0), 16'h0833, 8'h00}, 3, 4, 1, 0, 8'h00, 8'h00);
        bb_case({~`SEWP_DEV_CODE, 28'h0}, 1, 0, 0, 0, 8'h00, 8'h00);
        for (int it = 0; it < 4; it++) begin
            a = (it == 0) ? 4'hF : 4'($urandom);
            d = (it == 0) ? 8'hFF : 8'($urandom);
            run(sewp_pkg::OP_WRITE, a, d);
            chk_bit("write ack", 1'h1, rsp_ack);
            chk_bit("busy", 1'h1, busy1);
            chk_byte("waddr", {4'h0, a}, {4'h0, waddr1});
            mem[a] = d;
            if (it == 1) begin
                run(sewp_pkg::OP_WRITE, ~a, ~d);
                chk_bit("busy ack", 1'h0, rsp_ack);
            end
            run(sewp_pkg::OP_POLL, 4'h0, 8'h00);
            chk_bit("poll ack", 1'h1, rsp_ack);
            chk_byte("commits", 8'(it + 1), 8'(pulses1));
            chk_byte("wdata", d, wdata1);
            run(sewp_pkg::OP_RCUR, 4'h0, 8'h00);
            chk_byte("cur read", mem[a], rsp_data);
            run(sewp_pkg::OP_RCUR, 4'h0, 8'h00);
            chk_byte("next read", mem[a + 4'h1], rsp_data);
            b = 4'($urandom);
            run(sewp_pkg::OP_RRND, b, 8'h00);
            chk_byte("rnd read", mem[b], rsp_data);
        end
        finish_test();
    end
endmodule // tb_serial_eeprom_write_poll
`default_nettype wire
